// >>> rtl/rsw_pkg.sv
// Package for the reset-cause, sleep and wake block.
// Assumes a single 40 MHz core clock and a classic Wishbone register port.
package rsw_pkg;

  // Register byte offsets
  localparam logic [7:0] RSW_ADDR_STATUS = 8'h00;
  localparam logic [7:0] RSW_ADDR_CTRL = 8'h04;
  localparam logic [7:0] RSW_ADDR_WDOG = 8'h08;
  localparam logic [7:0] RSW_ADDR_PROT = 8'h0c;
  localparam logic [7:0] RSW_ADDR_IDW0 = 8'h10;
  localparam logic [7:0] RSW_ADDR_PROG = 8'h20;

  // Status register field positions
  localparam int RSW_BIT_WAKE_FLAG = 7;
  localparam int RSW_BIT_EXPIRED_N = 4;
  localparam int RSW_BIT_SLEEP_N = 3;
  localparam int RSW_BIT_ASLEEP = 0;

  // Control register field positions
  localparam int RSW_BIT_SLEEP_CMD = 0;
  localparam int RSW_BIT_CLR_WDOG = 1;
  localparam int RSW_BIT_WDOG_EN = 2;
  localparam int RSW_BIT_WAKE_EN = 3;
  localparam int RSW_BIT_EXTRST_EN = 4;
  localparam int RSW_BIT_PORT_READ = 5;

  // Reset values
  localparam logic [7:0] RSW_CTRL_RST = 8'h1c;
  localparam logic [15:0] RSW_WDOG_LIMIT_RST = 16'h02d0;

  // Program memory protection
  localparam logic [9:0] RSW_OPEN_LOW_LIMIT = 10'h040;
  localparam logic [9:0] RSW_TRIM_ADDR = 10'h3ff;
  localparam int RSW_NUM_ID = 4;

  // Serial programming framing
  localparam logic [4:0] RSW_CMD_BITS = 5'h06;
  localparam logic [4:0] RSW_DATA_BITS = 5'h0e;
  localparam logic [5:0] RSW_CMD_LOAD = 6'h02;
  localparam logic [5:0] RSW_CMD_READ = 6'h04;

  typedef enum logic [1:0] {RSW_RUN, RSW_SLEEP, RSW_PROG} rsw_mode_t;
  typedef enum logic [1:0] {RSW_P_CMD, RSW_P_LOAD, RSW_P_READ} rsw_pstate_t;

  // Wishbone request bundle
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } rsw_wb_req_t;

  // Serial programming pin bundle
  typedef struct packed {
    logic vpp_high;
    logic clk;
    logic data;
  } rsw_prog_pins_t;

endpackage : rsw_pkg

// >>> rtl/rsw_top.sv
// Reset-cause flags, sleep entry, wake-up, watchdog and serial programming framing.
// Assumes synchronous pins, a classic Wishbone master and a core clock enable.
`timescale 1ns/1ps
module rsw_top (
  // Clock, reset and enable
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  input wire logic I_CE,
  // Wishbone slave
  input wire rsw_pkg::rsw_wb_req_t I_WB,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  // Pins and configuration
  input wire logic [3:0] I_WAKE_PINS,
  input wire logic I_EXT_RESET_PIN_N,
  input wire logic I_CODE_PROTECT,
  input wire rsw_pkg::rsw_prog_pins_t I_PROG,
  input wire logic [7:0] I_PORT_OUT,
  input wire logic [7:0] I_PORT_OE,
  // Program memory read port
  output logic [9:0] O_MEM_ADDR,
  input wire logic [13:0] I_MEM_DATA,
  // Outputs
  output logic [7:0] O_PORT_OUT,
  output logic [7:0] O_PORT_OE,
  output logic O_OSC_RUN,
  output logic O_CORE_RESET,
  output logic O_EXT_RESET_PIN_OE,
  output logic O_PROG_DATA_OUT,
  output logic O_PROG_DATA_OE
);
  import rsw_pkg::*;

  typedef struct packed {
    rsw_mode_t mode;
    logic pin_change_wake_flag;
    logic watchdog_expired_n;
    logic sleep_entered_n;
    logic [7:0] ctrl;
    logic [15:0] wdog_limit;
    logic [15:0] watchdog_counter;
    logic [3:0] wake_ref;
    logic [3:0][13:0] id_word;
    logic [13:0] prot_latch;
    logic ext_prev;
    logic vpp_prev;
    logic pclk_prev;
    rsw_pstate_t pstate;
    logic [4:0] pcount;
    logic [5:0] pcmd;
    logic [13:0] pshift;
    logic [9:0] paddr;
    logic [31:0] wb_dat;
    logic wb_ack;
    logic [7:0] port_out;
    logic [7:0] port_oe;
    logic osc_run;
    logic core_reset;
    logic pdata_out;
    logic pdata_oe;
  } rsw_state_t;

  rsw_state_t st;
  rsw_state_t next_st;

  logic wb_req;
  logic ext_fall;
  logic wdog_hit;
  logic pin_diff;
  logic pclk_rise;

  ////////////////////////////////////////////////////////////////////////////
  // Event decode
  always_comb begin
    wb_req = I_WB.cyc && I_WB.stb && !st.wb_ack;
    ext_fall = st.ext_prev && !I_EXT_RESET_PIN_N && st.ctrl[RSW_BIT_EXTRST_EN];
    wdog_hit = st.ctrl[RSW_BIT_WDOG_EN] && (st.watchdog_counter >= st.wdog_limit);
    // Compare against the last captured port value
    pin_diff = st.ctrl[RSW_BIT_WAKE_EN] && (I_WAKE_PINS != st.wake_ref);
    pclk_rise = I_PROG.clk && !st.pclk_prev;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_st = st;
    next_st.wb_ack = 1'b0;
    next_st.core_reset = 1'b0;
    next_st.ext_prev = I_EXT_RESET_PIN_N;
    next_st.vpp_prev = I_PROG.vpp_high;
    next_st.pclk_prev = I_PROG.clk;
    next_st.ctrl[RSW_BIT_SLEEP_CMD] = 1'b0;
    next_st.ctrl[RSW_BIT_CLR_WDOG] = 1'b0;
    next_st.ctrl[RSW_BIT_PORT_READ] = 1'b0;
    // Watchdog runs while running or asleep, stops in program mode
    if (st.mode != RSW_PROG) begin
      next_st.watchdog_counter = st.watchdog_counter + 16'h0001;
    end
    // Port follows core only while awake; frozen in sleep
    if (st.mode == RSW_RUN) begin
      next_st.port_out = I_PORT_OUT;
      next_st.port_oe = I_PORT_OE;
    end
    // Reset-pin output never enabled; a watchdog reset stays internal
    case (st.mode)
      RSW_RUN: begin
        if (ext_fall) begin
          next_st.pin_change_wake_flag = 1'b0;
          next_st.core_reset = 1'b1;
          next_st.watchdog_counter = 16'h0000;
        end else if (wdog_hit) begin
          next_st.pin_change_wake_flag = 1'b0;
          next_st.watchdog_expired_n = 1'b0;
          next_st.core_reset = 1'b1;
          next_st.watchdog_counter = 16'h0000;
        end else if (st.ctrl[RSW_BIT_SLEEP_CMD]) begin
          next_st.mode = RSW_SLEEP;
          next_st.watchdog_counter = 16'h0000;
          next_st.watchdog_expired_n = 1'b1;
          next_st.sleep_entered_n = 1'b0;
          next_st.osc_run = 1'b0;
        end else if (st.ctrl[RSW_BIT_CLR_WDOG]) begin
          next_st.watchdog_counter = 16'h0000;
        end
        // Port read re-captures the change reference
        if (st.ctrl[RSW_BIT_PORT_READ]) begin
          next_st.wake_ref = I_WAKE_PINS;
        end
      end
      RSW_SLEEP: begin
        // Any enabled source wakes with a device reset
        if (ext_fall || wdog_hit || pin_diff) begin
          next_st.mode = RSW_RUN;
          next_st.osc_run = 1'b1;
          next_st.core_reset = 1'b1;
          next_st.watchdog_counter = 16'h0000;
          next_st.sleep_entered_n = 1'b0;
          if (ext_fall) begin
            next_st.pin_change_wake_flag = 1'b0;
            next_st.watchdog_expired_n = 1'b1;
          end else if (wdog_hit) begin
            next_st.pin_change_wake_flag = 1'b0;
            next_st.watchdog_expired_n = 1'b0;
          end else begin
            // Reference not refreshed, so a stale mismatch wakes again
            next_st.pin_change_wake_flag = 1'b1;
            next_st.watchdog_expired_n = 1'b1;
          end
        end
      end
      default: begin
        // Program mode ends when the programming level drops
        if (!I_PROG.vpp_high) begin
          next_st.mode = RSW_RUN;
          next_st.pdata_oe = 1'b0;
          next_st.core_reset = 1'b1;
        end else if (pclk_rise) begin
          // Serial framing on pin 1 clock and pin 0 data
          case (st.pstate)
            RSW_P_CMD: begin
              next_st.pcmd = {I_PROG.data, st.pcmd[5:1]};
              next_st.pcount = st.pcount + 5'h01;
              if (st.pcount == RSW_CMD_BITS - 5'h01) begin
                next_st.pcount = 5'h00;
                if ({I_PROG.data, st.pcmd[5:1]} == RSW_CMD_LOAD) begin
                  next_st.pstate = RSW_P_LOAD;
                end else if ({I_PROG.data, st.pcmd[5:1]} == RSW_CMD_READ) begin
                  next_st.pstate = RSW_P_READ;
                  next_st.pshift = st.prot_latch;
                  next_st.pdata_oe = 1'b1;
                  next_st.pdata_out = st.prot_latch[0];
                end else begin
                  next_st.paddr = st.paddr + 10'h001;
                end
              end
            end
            RSW_P_LOAD: begin
              next_st.pshift = {I_PROG.data, st.pshift[13:1]};
              next_st.pcount = st.pcount + 5'h01;
              if (st.pcount == RSW_DATA_BITS - 5'h01) begin
                next_st.pcount = 5'h00;
                next_st.pstate = RSW_P_CMD;
                // ID words writable only here
                if (st.paddr < 10'(RSW_NUM_ID)) begin
                  next_st.id_word[st.paddr[1:0]] = {I_PROG.data, st.pshift[13:1]};
                end
              end
            end
            default: begin
              next_st.pshift = {1'b0, st.pshift[13:1]};
              next_st.pdata_out = st.pshift[1];
              next_st.pcount = st.pcount + 5'h01;
              if (st.pcount == RSW_DATA_BITS - 5'h01) begin
                next_st.pcount = 5'h00;
                next_st.pstate = RSW_P_CMD;
                next_st.pdata_oe = 1'b0;
              end
            end
          endcase
        end
      end
    endcase
    // Read gate for program memory
    if (st.paddr < 10'(RSW_NUM_ID)) begin
      next_st.prot_latch = st.id_word[st.paddr[1:0]];
    end else if (!I_CODE_PROTECT || st.paddr < RSW_OPEN_LOW_LIMIT
                 || st.paddr == RSW_TRIM_ADDR) begin
      next_st.prot_latch = I_MEM_DATA;
    end else begin
      next_st.prot_latch = 14'h0000;
    end
    // Program entry on rising programming level with clock and data low
    if (st.mode != RSW_PROG && I_PROG.vpp_high && !st.vpp_prev
        && !I_PROG.clk && !I_PROG.data) begin
      next_st.mode = RSW_PROG;
      next_st.pstate = RSW_P_CMD;
      next_st.pcount = 5'h00;
      next_st.paddr = 10'h000;
      next_st.osc_run = 1'b1;
    end
    // Wishbone slave, one registered ack per request, a cycle after the request
    if (wb_req) begin
      next_st.wb_ack = 1'b1;
      next_st.wb_dat = 32'h0000_0000;
      if (I_WB.adr == RSW_ADDR_STATUS) begin
        // Cause flags read-only
        next_st.wb_dat[RSW_BIT_WAKE_FLAG] = st.pin_change_wake_flag;
        next_st.wb_dat[RSW_BIT_EXPIRED_N] = st.watchdog_expired_n;
        next_st.wb_dat[RSW_BIT_SLEEP_N] = st.sleep_entered_n;
        next_st.wb_dat[RSW_BIT_ASLEEP] = (st.mode == RSW_SLEEP);
      end else if (I_WB.adr == RSW_ADDR_CTRL) begin
        next_st.wb_dat[7:0] = st.ctrl;
        if (I_WB.we && I_WB.sel[0]) begin
          next_st.ctrl = I_WB.dat[7:0];
        end
      end else if (I_WB.adr == RSW_ADDR_WDOG) begin
        next_st.wb_dat[15:0] = st.watchdog_counter;
        if (I_WB.we && I_WB.sel[0]) begin
          next_st.wdog_limit[7:0] = I_WB.dat[7:0];
        end
        if (I_WB.we && I_WB.sel[1]) begin
          next_st.wdog_limit[15:8] = I_WB.dat[15:8];
        end
      end else if (I_WB.adr == RSW_ADDR_PROT) begin
        next_st.wb_dat[15:0] = st.wdog_limit;
      end else if (I_WB.adr == RSW_ADDR_PROG) begin
        next_st.wb_dat[1:0] = st.pstate;
      end
      // ID words are not reachable from software
    end
    if (I_RST) begin
      next_st = '0;
      next_st.mode = RSW_RUN;
      next_st.pstate = RSW_P_CMD;
      next_st.watchdog_expired_n = 1'b1;
      next_st.sleep_entered_n = 1'b1;
      next_st.ctrl = RSW_CTRL_RST;
      next_st.wdog_limit = RSW_WDOG_LIMIT_RST;
      next_st.ext_prev = 1'b1;
      next_st.osc_run = 1'b1;
      next_st.core_reset = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register, frozen while the enable is low unless reset is high
  always_ff @(posedge I_REF_CLK) begin
    if (I_CE || I_RST) begin
      st <= next_st;
    end
  end

  // Outputs straight from state; reset-pin enable tied low
  always_comb begin
    O_WB_DAT = st.wb_dat;
    O_WB_ACK = st.wb_ack;
    O_PORT_OUT = st.port_out;
    O_PORT_OE = st.port_oe;
    O_OSC_RUN = st.osc_run;
    O_CORE_RESET = st.core_reset;
    O_EXT_RESET_PIN_OE = 1'b0;
    O_PROG_DATA_OUT = st.pdata_out;
    O_PROG_DATA_OE = st.pdata_oe;
    O_MEM_ADDR = st.paddr;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence wd_sleep_wake_s;
    st.mode == RSW_SLEEP && wdog_hit && !ext_fall && I_CE;
  endsequence

  wd_wake_flags_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    wd_sleep_wake_s |=> !st.watchdog_expired_n && !st.sleep_entered_n
      && !st.pin_change_wake_flag && st.core_reset)
    else $error("watchdog wake flags wrong");

  wd_run_flags_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (st.mode == RSW_RUN && wdog_hit && !ext_fall && I_CE)
      |=> !st.watchdog_expired_n && $stable(st.sleep_entered_n) && !st.pin_change_wake_flag)
    else $error("watchdog run flags wrong");

  pin_wake_flags_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (st.mode == RSW_SLEEP && pin_diff && !wdog_hit && !ext_fall && I_CE)
      |=> st.pin_change_wake_flag && st.watchdog_expired_n && st.mode == RSW_RUN)
    else $error("pin wake flags wrong");

  ext_sleep_flags_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (st.mode == RSW_SLEEP && ext_fall && I_CE)
      |=> st.watchdog_expired_n && !st.sleep_entered_n && !st.pin_change_wake_flag)
    else $error("reset pin wake flags wrong");

  sleep_entry_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (st.mode == RSW_RUN && st.ctrl[RSW_BIT_SLEEP_CMD] && !ext_fall && !wdog_hit && I_CE)
      |=> st.mode == RSW_SLEEP && !st.osc_run && st.watchdog_counter == 16'h0000)
    else $error("sleep entry wrong");

  port_frozen_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (st.mode == RSW_SLEEP) ##1 (st.mode == RSW_SLEEP) |-> $stable(st.port_out)
      && $stable(st.port_oe))
    else $error("port changed in sleep");

  reset_pin_quiet_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    st.core_reset |-> !O_EXT_RESET_PIN_OE)
    else $error("reset pin driven");

  wake_clears_wd_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (st.mode == RSW_SLEEP && I_CE) ##1 (st.mode == RSW_RUN)
      |-> st.watchdog_counter == 16'h0000)
    else $error("watchdog not cleared at wake");

  flags_hold_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (st.mode == RSW_RUN && !ext_fall && !wdog_hit && !st.ctrl[RSW_BIT_SLEEP_CMD])
      |=> $stable(st.pin_change_wake_flag) && $stable(st.watchdog_expired_n))
    else $error("flags changed without event");

  // Read gate and serial data pin; a leak here would expose protected words
  prot_gate_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (I_CE && I_CODE_PROTECT && st.paddr >= RSW_OPEN_LOW_LIMIT && st.paddr != RSW_TRIM_ADDR)
      |=> st.prot_latch == 14'h0000)
    else $error("protected word not masked");

  open_read_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (I_CE && st.paddr >= 10'(RSW_NUM_ID)
      && (!I_CODE_PROTECT || st.paddr < RSW_OPEN_LOW_LIMIT))
      |=> st.prot_latch == $past(I_MEM_DATA))
    else $error("open word not readable");

  pdata_idle_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (st.mode != RSW_PROG) |-> !st.pdata_oe)
    else $error("data pin driven outside program mode");

endmodule : rsw_top

// >>> bench/rsw_partner.sv
// Far-side model: reset pin, wake pins and a serial programmer.
// Assumes the bench resolves the programming data line and feeds it back.
`timescale 1ns/1ps
module rsw_partner (
  // Clock
  input wire logic i_clk,
  // Resolved programming data line
  input wire logic i_prog_line,
  // Pins driven by the far side
  output logic o_reset_pin_n,
  output logic [3:0] o_wake_pins,
  output rsw_pkg::rsw_prog_pins_t o_prog
);
  import rsw_pkg::*;
  localparam int HALF = 4;
  ////////////////////////////////////////////////////////////////////////////////
  // Idle levels; the serial clock stands low outside frames
  initial begin
    o_reset_pin_n = 1'b1;
    o_wake_pins = 4'h0;
    o_prog = '0;
  end
  // Reset pin low pulse of a few cycles
  task automatic pulse_reset();
    @(posedge i_clk) o_reset_pin_n <= 1'b0;
    repeat (4) @(posedge i_clk);
    o_reset_pin_n <= 1'b1;
  endtask : pulse_reset
  task automatic set_wake(input logic [3:0] v);
    @(posedge i_clk) o_wake_pins <= v;
  endtask : set_wake
  // Clock and data held low while the programming level rises
  task automatic enter_prog();
    @(posedge i_clk) o_prog <= '0;
    repeat (4) @(posedge i_clk);
    o_prog.vpp_high <= 1'b1;
    repeat (4) @(posedge i_clk);
  endtask : enter_prog
  task automatic leave_prog();
    @(posedge i_clk) o_prog <= '0;
    repeat (8) @(posedge i_clk);
  endtask : leave_prog
  ////////////////////////////////////////////////////////////////////////////////
  // LSB first, data stable around each clock rise
  task automatic send_bits(input logic [13:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge i_clk) o_prog.data <= v[i];
      o_prog.clk <= 1'b0;
      repeat (HALF) @(posedge i_clk);
      o_prog.clk <= 1'b1;
      repeat (HALF - 1) @(posedge i_clk);
    end
    // Released line must not keep the last value
    @(posedge i_clk) o_prog.clk <= 1'b0;
    o_prog.data <= ~v[n-1];
  endtask : send_bits
  task automatic send_cmd(input logic [5:0] c);
    send_bits({8'h00, c}, 6);
  endtask : send_cmd
  task automatic send_data(input logic [13:0] d);
    send_bits(d, 14);
  endtask : send_data
  // Each bit is sampled late in the low phase, before the rise that advances it
  task automatic recv_data(output logic [13:0] v);
    for (int i = 0; i < 14; i++) begin
      @(posedge i_clk) o_prog.clk <= 1'b0;
      o_prog.data <= ~o_prog.data;
      repeat (HALF) @(posedge i_clk);
      @(negedge i_clk) v[i] = i_prog_line;
      @(posedge i_clk) o_prog.clk <= 1'b1;
      repeat (HALF - 1) @(posedge i_clk);
    end
    @(posedge i_clk) o_prog.clk <= 1'b0;
  endtask : recv_data
endmodule : rsw_partner

// >>> bench/tb_top.sv
// Self-checking bench for the reset-cause, sleep and wake block.
// Assumes a classic Wishbone port and the partner model for the far-side pins.
`timescale 1ns/1ps
module tb_top;
  import rsw_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic prot = 1'b0;
  logic [7:0] p_out = 8'h00;
  logic [7:0] p_oe = 8'h00;
  rsw_wb_req_t wb = '0;
  rsw_prog_pins_t pp;
  rsw_prog_pins_t prog_in;
  logic [31:0] wb_dat;
  logic wb_ack, rst_n, d_out, d_oe;
  logic [3:0] wake;
  logic [7:0] o_out, o_oe;
  logic osc_run, core_rst, pin_oe;
  logic [13:0] pv;
  logic [9:0] mem_a;
  logic [31:0] rd;
  int error_cnt = 0;
  int checked = 0;
  int cycles = 0;
  always #12.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  // Data line: whoever enables drives it
  // Model memory word carries its own address, so a wrong address shows
  assign prog_in = '{vpp_high: pp.vpp_high, clk: pp.clk, data: d_oe ? d_out : pp.data};
  rsw_top rsw_top_inst (.I_REF_CLK(clk), .I_RST(rst), .I_CE(1'b1), .I_WB(wb),
    .O_WB_DAT(wb_dat), .O_WB_ACK(wb_ack), .I_WAKE_PINS(wake), .I_EXT_RESET_PIN_N(rst_n),
    .I_CODE_PROTECT(prot), .I_PROG(prog_in), .I_PORT_OUT(p_out), .I_PORT_OE(p_oe),
    .O_MEM_ADDR(mem_a), .I_MEM_DATA({4'h5, mem_a}), .O_PORT_OUT(o_out), .O_PORT_OE(o_oe),
    .O_OSC_RUN(osc_run), .O_CORE_RESET(core_rst), .O_EXT_RESET_PIN_OE(pin_oe),
    .O_PROG_DATA_OUT(d_out), .O_PROG_DATA_OE(d_oe));
  rsw_partner rsw_partner_inst (.i_clk(clk), .i_prog_line(prog_in.data),
    .o_reset_pin_n(rst_n), .o_wake_pins(wake), .o_prog(pp));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("Mismatches %0d, comparisons %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run
  // Hang guard, well above the few thousand cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One classic cycle; request held until ack is sampled
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk) wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    if (n == 50) check(1'b0, 1'b1);
    rd = wb_dat;
    wb <= '0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    check(rd & m, e);
  endtask : rd_chk
  // Bounded wait for the core reset pulse
  task automatic wait_rst();
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (core_rst !== 1'b1 && n < 300);
    check({31'h0, core_rst}, 32'h1);
  endtask : wait_rst
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd_chk(RSW_ADDR_STATUS, 32'h99, 32'h18);
    rd_chk(RSW_ADDR_CTRL, 32'hff, 32'h1c);
    rd_chk(RSW_ADDR_PROT, 32'hffff, 32'h02d0);
    rd_chk(RSW_ADDR_IDW0, 32'hffffffff, 32'h0);
    rd_chk(8'h3c, 32'hffffffff, 32'h0);
    wr(RSW_ADDR_STATUS, 32'h0);
    rd_chk(RSW_ADDR_STATUS, 32'h99, 32'h18);
    // Watchdog expiry while running
    wr(RSW_ADDR_WDOG, 32'h20);
    wait_rst();
    rd_chk(RSW_ADDR_STATUS, 32'h99, 32'h08);
    check({31'h0, pin_oe}, 32'h0);
    // Watchdog off; reset pin while running leaves the watchdog and sleep flags alone
    wr(RSW_ADDR_CTRL, 32'h18);
    rsw_partner_inst.pulse_reset();
    repeat (4) @(posedge clk);
    rd_chk(RSW_ADDR_STATUS, 32'h99, 32'h08);
    // Recapture, then sleep with frozen port
    p_out <= 8'h5a;
    p_oe <= 8'hf0;
    wr(RSW_ADDR_CTRL, 32'h38);
    wr(RSW_ADDR_CTRL, 32'h19);
    p_out <= 8'ha5;
    p_oe <= 8'h0f;
    rd_chk(RSW_ADDR_STATUS, 32'h99, 32'h11);
    check({31'h0, osc_run}, 32'h0);
    check({16'h0, o_out, o_oe}, 32'h5af0);
    fork
      rsw_partner_inst.set_wake(4'h1);
      wait_rst();
    join
    rd_chk(RSW_ADDR_STATUS, 32'h99, 32'h90);
    check({31'h0, osc_run}, 32'h1);
    // Sleep again without a port read: stale mismatch wakes at once
    wr(RSW_ADDR_CTRL, 32'h19);
    wait_rst();
    rd_chk(RSW_ADDR_STATUS, 32'h99, 32'h90);
    // Reset pin wake
    wr(RSW_ADDR_CTRL, 32'h38);
    wr(RSW_ADDR_CTRL, 32'h19);
    fork
      rsw_partner_inst.pulse_reset();
      wait_rst();
    join
    rd_chk(RSW_ADDR_STATUS, 32'h99, 32'h10);
    // Watchdog wake from sleep
    wr(RSW_ADDR_WDOG, 32'h20);
    wr(RSW_ADDR_CTRL, 32'h1c);
    wr(RSW_ADDR_CTRL, 32'h1d);
    xfer(1'b0, RSW_ADDR_WDOG, 32'h0);
    check({31'h0, rd <= 32'h4}, 32'h1);
    wait_rst();
    rd_chk(RSW_ADDR_STATUS, 32'h99, 32'h00);
    xfer(1'b0, RSW_ADDR_WDOG, 32'h0);
    check({31'h0, rd <= 32'h8}, 32'h1);
    // Software clear of the watchdog restarts the count
    wr(RSW_ADDR_CTRL, 32'h1e);
    xfer(1'b0, RSW_ADDR_WDOG, 32'h0);
    check({31'h0, rd <= 32'h2}, 32'h1);
    wr(RSW_ADDR_CTRL, 32'h18);
    // Serial programming: ID word then a protected-mode low address
    prot <= 1'b1;
    rsw_partner_inst.enter_prog();
    rsw_partner_inst.send_cmd(RSW_CMD_LOAD);
    rd_chk(RSW_ADDR_PROG, 32'h3, {30'h0, RSW_P_LOAD});
    rsw_partner_inst.send_data(14'h000b);
    rsw_partner_inst.send_cmd(RSW_CMD_READ);
    rsw_partner_inst.recv_data(pv);
    check({18'h0, pv}, 32'h000b);
    for (int i = 0; i < 4; i++) begin
      rsw_partner_inst.send_cmd(6'h06);
    end
    rsw_partner_inst.send_cmd(RSW_CMD_READ);
    rsw_partner_inst.recv_data(pv);
    check({18'h0, pv}, 32'h1404);
    check({31'h0, d_oe}, 32'h0);
    // Step past the open range: masked while protected, readable once protection is off
    for (int i = 4; i < 64; i++) begin
      rsw_partner_inst.send_cmd(6'h06);
    end
    rsw_partner_inst.send_cmd(RSW_CMD_READ);
    rsw_partner_inst.recv_data(pv);
    check({18'h0, pv}, 32'h0);
    prot <= 1'b0;
    rsw_partner_inst.send_cmd(RSW_CMD_READ);
    rsw_partner_inst.recv_data(pv);
    check({18'h0, pv}, 32'h1440);
    rsw_partner_inst.leave_prog();
    complete_run();
  end
endmodule : tb_top
